// >>> bench/adct_ctrl_asserts.sv
// Concurrent checks on the ports of the converter control block.
// Assumes binding onto adct_conv_ctrl; one clock, synchronous reset.
module adct_ctrl_asserts (
    input wire clk_sys,
    input wire sys_rst,
    input wire [11:0] paddr,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] pwdata,
    input wire pready,
    input wire pslverr,
    input wire [4:0] channelSelect,
    input wire [1:0] referenceSelect,
    input wire diffMode,
    input wire halfRateConvClock,
    input wire convBusy,
    input wire sleepRequest,
    input wire cpuWake
);
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (sys_rst);
    // ==========================================================
    // Assertions
    AST_SEL_COPY: assert property (psel && penable && pwrite && paddr == 12'h000
        && !convBusy ##1 !convBusy [*2] |=> channelSelect == $past(pwdata[4:0], 3)
        && referenceSelect == $past(pwdata[7:6], 3)) else $error("selection not copied");
    AST_SEL_HOLD: assert property (convBusy && $past(convBusy) && $changed(channelSelect)
        |-> ##[0:12] !convBusy) else $error("selection moved during conversion");
    AST_DIFF: assert property (diffMode == (channelSelect >= 5'h08))
        else $error("differential flag wrong");
    AST_HALF_TOGGLE: assert property ($fell(halfRateConvClock) |=> !halfRateConvClock)
        else $error("half rate clock too fast");
    AST_BUSY_MIN: assert property ($rose(convBusy) |=> convBusy [*8])
        else $error("conversion too short");
    AST_WAKE_PULSE: assert property (cpuWake |=> !cpuWake)
        else $error("wake not a pulse");
    AST_WAKE_CAUSE: assert property (cpuWake |-> $past(convBusy) && !convBusy)
        else $error("wake without completion");
    AST_WAKE_SLEEP: assert property (cpuWake |=> !sleepRequest)
        else $error("sleep request kept after wake");
    AST_APB: assert property (pready && !pslverr)
        else $error("bus answer wrong");
endmodule // adct_ctrl_asserts

bind adct_conv_ctrl adct_ctrl_asserts i_adct_ctrl_asserts (.clk_sys, .sys_rst, .paddr, .psel,
    .penable, .pwrite, .pwdata, .pready, .pslverr, .channelSelect, .referenceSelect,
    .diffMode, .halfRateConvClock, .convBusy, .sleepRequest, .cpuWake);

// >>> bench/tb.sv
// Self-checking bench for the converter control block.
// Assumes the checker bound to adct_conv_ctrl; APB master with queued expectations.
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 0;
    logic sys_rst = 1;
    logic [11:0] paddr = 0;
    logic psel = 0;
    logic penable = 0;
    logic pwrite = 0;
    logic [31:0] pwdata = 0;
    logic [31:0] prdata;
    logic pready, pslverr, diffMode, halfRateConvClock, convBusy, sleepRequest, cpuWake;
    logic convIrq;
    logic cpuHalted = 0;
    logic [9:0] sampleResult = 0;
    logic [4:0] channelSelect;
    logic [1:0] referenceSelect;
    logic half;
    logic [31:0] expRd[$];
    int expLen[$];
    int seed = 89889;
    int mismatches = 0;
    int cmp_count = 0;
    int cycles = 0;
    int busyCnt = 0;
    int wakes = 0;
    int i, k, n, w;
    logic [31:0] d;

    adct_conv_ctrl i_adct_conv_ctrl (.clk_sys, .sys_rst, .paddr, .psel, .penable, .pwrite,
        .pwdata, .prdata, .pready, .pslverr, .triggerEvent(1'b0), .cpuHalted, .sampleResult,
        .channelSelect, .referenceSelect, .diffMode, .halfRateConvClock, .convBusy,
        .sleepRequest, .cpuWake, .convIrq);

    initial begin
        forever #4 clk_sys = ~clk_sys;
    end
    // ==========================================================
    // Checking and closing
    task automatic check(input bit ok, input string msg);
        cmp_count++;
        if (!ok) begin
            mismatches++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // Watches reads, conversion lengths and wake pulses
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (psel && penable && pready === 1'b1 && !pwrite)
            check(prdata === expRd.pop_front(), "read data");
        if (cpuWake === 1'b1) wakes <= wakes + 1;
        if (convBusy === 1'b1) busyCnt <= busyCnt + 1;
        else if (busyCnt != 0) begin
            n = expLen.pop_front();
            // Busy spans the wait for the next tick (1 to 8 clocks) plus n ticks of 8 clocks
            check(busyCnt >= n * 8 + 1 && busyCnt <= n * 8 + 8, "conversion length");
            busyCnt <= 0;
        end
        if (cycles == 20000) begin
            mismatches++;
            end_of_test();
        end
    end
    // ==========================================================
    // APB master
    task automatic apb(input logic [11:0] a, input logic wr, input logic [31:0] v);
        psel <= 1;
        paddr <= a;
        pwrite <= wr;
        pwdata <= v;
        @(posedge clk_sys);
        penable <= 1;
        @(posedge clk_sys);
        while (pready !== 1'b1) @(posedge clk_sys);
        half = halfRateConvClock;
        psel <= 0;
        penable <= 0;
        @(posedge clk_sys);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        expRd.push_back(e);
        apb(a, 0, 0);
    endtask
    task automatic waitBusy(input logic lvl);
        for (k = 0; k < 400 && convBusy !== lvl; k++) @(posedge clk_sys);
    endtask
    // One conversion with prescaler 8, done cleared by the start write
    task automatic conv(input logic [4:0] ch, input bit first);
        logic [9:0] res;
        res = 10'($random(seed));
        apb(12'h000, 1, {27'h0, ch});
        d = $random(seed);
        repeat (d[2:0]) @(posedge clk_sys);
        sampleResult <= res;
        apb(12'h004, 1, 32'hd3);
        // Half-rate clock toggles once more at the tick edge before the start edge
        expLen.push_back(first ? 25 : (ch >= 5'h08 && !half) ? 14 : 13);
        if (!first) begin
            // reselect only well after the start bit, during conversion
            repeat (20) @(posedge clk_sys);
            apb(12'h000, 1, {27'h0, ch ^ 5'h04});
            @(posedge clk_sys);
            check(channelSelect === ch, "selection not frozen");
        end
        waitBusy(1'b0);
        rd(12'h00c, {22'h0, res});
        rd(12'h004, 32'h93);
    endtask
    // ==========================================================
    // Main sequence
    initial begin
        repeat (2) @(posedge clk_sys);
        sys_rst <= 0;
        @(posedge clk_sys);
        // Status shows the idle state code after reset
        for (i = 0; i < 5; i++) rd(12'(i * 4), (i == 4) ? 32'h80 : 32'h0);
        apb(12'h020, 1, $random(seed));
        rd(12'h020, 32'h0);
        apb(12'h004, 1, 32'h03);
        repeat (20) @(posedge clk_sys);
        check(halfRateConvClock === 1'b0, "half rate clock runs while off");
        apb(12'h004, 1, 32'h83);
        for (i = 0; i < 4; i++) begin
            d = $random(seed);
            d[7:6] = (i == 3) ? 2'h1 : 2'(i + i[1]);
            apb(12'h000, 1, {24'h0, d[7:6], 1'b0, d[4:0]});
            @(posedge clk_sys);
            check(channelSelect === d[4:0] && referenceSelect === d[7:6], "selection");
            rd(12'h000, {24'h0, d[7:6], 1'b0, d[4:0]});
        end
        conv(5'h01, 1);
        for (i = 0; i < 10; i++) begin
            d = $random(seed);
            conv({1'b0, i[0], d[2:0]}, 0);
        end
        apb(12'h004, 1, 32'h03);
        apb(12'h004, 1, 32'h83);
        // results here are only compared as data, never used as settled values
        conv(5'h09, 1);
        apb(12'h000, 1, 32'h02);
        for (i = 0; i < 3; i++) begin
            apb(12'h004, 1, 32'h9b);
            apb(12'h008, 1, {28'h0, 3'(i ^ 1), 1'b1});
            w = wakes;
            if (i < 2) expLen.push_back(13);
            cpuHalted <= 1;
            repeat (3) @(posedge clk_sys);
            if (i < 2) begin
                waitBusy(1'b1);
                check(convBusy === 1'b1, "no start on halt");
                repeat (10) @(posedge clk_sys);
                if (i == 1) cpuHalted <= 0;
                waitBusy(1'b0);
                repeat (2) @(posedge clk_sys);
                cpuHalted <= 0;
                check(wakes === w + 1 && convIrq === 1'b1, "no wake on completion");
                repeat (10) @(posedge clk_sys);
                check(sleepRequest === 1'b0, "sleep kept after wake");
            end else begin
                repeat (40) @(posedge clk_sys);
                check(convBusy === 1'b0 && wakes === w, "start in other sleep");
                rd(12'h004, 32'h8b);
                cpuHalted <= 0;
                apb(12'h008, 1, 32'h0);
            end
        end
        end_of_test();
    end
endmodule // tb

// >>> logic/adct_conv_ctrl.v
// Converter control: APB registers, conversion sequencer, sleep start.
// Assumes an APB master on clk_sys; trigger and halt from same-domain logic.
`include "adct_defines.vh"
module adct_conv_ctrl (
    clk_sys,
    sys_rst,
    paddr,
    psel,
    penable,
    pwrite,
    pwdata,
    prdata,
    pready,
    pslverr,
    triggerEvent,
    cpuHalted,
    sampleResult,
    channelSelect,
    referenceSelect,
    diffMode,
    halfRateConvClock,
    convBusy,
    sleepRequest,
    cpuWake,
    convIrq
);
    input wire clk_sys;
    input wire sys_rst;
    input wire [11:0] paddr;
    input wire psel;
    input wire penable;
    input wire pwrite;
    input wire [31:0] pwdata;
    output reg [31:0] prdata;
    output wire pready;
    output wire pslverr;
    input wire triggerEvent;
    input wire cpuHalted;
    input wire [9:0] sampleResult;
    output wire [4:0] channelSelect;
    output wire [1:0] referenceSelect;
    output wire diffMode;
    output wire halfRateConvClock;
    output wire convBusy;
    output wire sleepRequest;
    output wire cpuWake;
    output wire convIrq;

    localparam ST_IDLE = 3'b001;
    localparam ST_SYNC = 3'b010;
    localparam ST_CONV = 3'b100;

    reg [7:0] inputSelectRegQ;
    reg [7:0] ctrlAQ;
    reg [3:0] sleepQ;
    reg [9:0] resultQ;
    reg [2:0] stateQ;
    reg [4:0] cycLeftQ;
    reg firstPendingQ;
    reg enPrevQ;
    reg trigPrevQ;
    reg trigArmedQ;
    reg sleepStartedQ;
    reg wakeQ;
    reg lockQ;
    reg trigReset;
    wire convTick;
    wire apbWrite;
    wire apbRead;
    wire convEn;
    wire trigRise;
    wire startReq;
    wire finishNow;
    wire sleepStart;

    // Differential channel test
    function isDiff;
        input [4:0] ch;
        begin
            isDiff = (ch >= `ADCT_DIFF_FIRST);
        end
    endfunction

    // Conversion length for start with given phase
    function [4:0] convLength;
        input first;
        input diff;
        input halfHigh;
        begin
            if (first) begin
                convLength = `ADCT_CYC_FIRST;
            end else if (diff && halfHigh) begin
                convLength = `ADCT_CYC_SYNC;
            end else begin
                convLength = `ADCT_CYC_NORMAL;
            end
        end
    endfunction

    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign apbWrite = psel && penable && pwrite;
    assign apbRead = psel && !penable && !pwrite;
    assign convEn = ctrlAQ[`ADCT_CA_EN];
    assign convBusy = ctrlAQ[`ADCT_CA_START];
    assign sleepRequest = sleepQ[`ADCT_SLP_REQ];
    assign cpuWake = wakeQ;
    assign diffMode = isDiff(channelSelect);
    assign trigRise = triggerEvent && !trigPrevQ;
    assign convIrq = ctrlAQ[`ADCT_CA_DONE] && ctrlAQ[`ADCT_CA_IE];
    // sleep conditions met and CPU halted
    assign sleepStart = sleepRequest && cpuHalted && !sleepStartedQ && convEn &&
        !ctrlAQ[`ADCT_CA_ATE] && ctrlAQ[`ADCT_CA_IE] && (stateQ == ST_IDLE) &&
        ((sleepQ[3:1] == `ADCT_SLP_IDLE) || (sleepQ[3:1] == `ADCT_SLP_NOISE));
    assign startReq = convEn && (convBusy || trigArmedQ || sleepStartedQ);
    assign finishNow = convTick && (stateQ == ST_CONV) && (cycLeftQ == 5'h01);

    // =====================================================
    // Prescaler and half-rate clock
    adct_prescaler uPresc (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .convEnable(convEn),
        .trigReset(trigReset),
        .prescSel(ctrlAQ[`ADCT_CA_PRESC_MSB:`ADCT_CA_PRESC_LSB]),
        .convTick(convTick),
        .halfRateConvClock(halfRateConvClock)
    );

    // =====================================================
    // Selection buffer
    // temporary register feeds buffer
    adct_sel_buffer uSel (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .tempChannel(inputSelectRegQ[`ADCT_SEL_CH_MSB:`ADCT_SEL_CH_LSB]),
        .tempReference(inputSelectRegQ[`ADCT_SEL_REF_MSB:`ADCT_SEL_REF_LSB]),
        .selLocked(lockQ),
        .channelSelect(channelSelect),
        .referenceSelect(referenceSelect)
    );

    // =====================================================
    // Register file
    always @(posedge clk_sys) begin
        if (sys_rst) begin
            inputSelectRegQ <= `ADCT_RST_BYTE;
            ctrlAQ <= `ADCT_RST_BYTE;
            sleepQ <= 4'h0;
            resultQ <= 10'h000;
        end else begin
            if (apbWrite && paddr == `ADCT_OFF_INSEL) begin
                inputSelectRegQ <= pwdata[7:0];
            end
            if (apbWrite && paddr == `ADCT_OFF_SLEEP) begin
                sleepQ <= pwdata[3:0];
            end else if (wakeQ) begin
                sleepQ[`ADCT_SLP_REQ] <= 1'b0;
            end
            if (apbWrite && paddr == `ADCT_OFF_CTRLA) begin
                ctrlAQ[`ADCT_CA_EN] <= pwdata[`ADCT_CA_EN];
                ctrlAQ[`ADCT_CA_ATE] <= pwdata[`ADCT_CA_ATE];
                ctrlAQ[`ADCT_CA_IE] <= pwdata[`ADCT_CA_IE];
                ctrlAQ[2:0] <= pwdata[2:0];
                ctrlAQ[`ADCT_CA_START] <= (convBusy || pwdata[`ADCT_CA_START] ||
                    sleepStart || trigRise) && pwdata[`ADCT_CA_EN] && !finishNow;
            end else if (!convEn) begin
                ctrlAQ[`ADCT_CA_START] <= 1'b0;
            end else if (sleepStart || (trigRise && ctrlAQ[`ADCT_CA_ATE])) begin
                ctrlAQ[`ADCT_CA_START] <= 1'b1;
            // start cleared at completion in single mode
            end else if (finishNow && !ctrlAQ[`ADCT_CA_ATE]) begin
                ctrlAQ[`ADCT_CA_START] <= 1'b0;
            end
            // done set, set wins over clear-by-one
            if (finishNow) begin
                ctrlAQ[`ADCT_CA_DONE] <= 1'b1;
                resultQ <= sampleResult;
            end else if (apbWrite && paddr == `ADCT_OFF_CTRLA && pwdata[`ADCT_CA_DONE]) begin
                ctrlAQ[`ADCT_CA_DONE] <= 1'b0;
            end
        end
    end

    // =====================================================
    // Conversion sequencer
    always @(posedge clk_sys) begin
        if (sys_rst) begin
            stateQ <= ST_IDLE;
            cycLeftQ <= 5'h00;
            firstPendingQ <= 1'b0;
            enPrevQ <= 1'b0;
            trigPrevQ <= 1'b0;
            trigArmedQ <= 1'b0;
            sleepStartedQ <= 1'b0;
            wakeQ <= 1'b0;
            lockQ <= 1'b0;
            trigReset <= 1'b0;
        end else begin
            enPrevQ <= convEn;
            trigPrevQ <= triggerEvent;
            trigReset <= 1'b0;
            wakeQ <= 1'b0;
            if (convEn && !enPrevQ) begin
                firstPendingQ <= 1'b1;
            end
            if (sleepStart) begin
                sleepStartedQ <= 1'b1;
            end
            if (trigRise && ctrlAQ[`ADCT_CA_ATE] && stateQ == ST_IDLE && convEn) begin
                trigArmedQ <= 1'b1;
                trigReset <= 1'b1;
            end
            if (!convEn) begin
                stateQ <= ST_IDLE;
                lockQ <= 1'b0;
                trigArmedQ <= 1'b0;
                sleepStartedQ <= 1'b0;
            end else begin
                case (stateQ)
                    ST_IDLE: begin
                        if (startReq && convTick) begin
                            stateQ <= ST_CONV;
                            lockQ <= 1'b1;
                            trigArmedQ <= 1'b0;
                            // first conversion gives 25; otherwise low phase gives 13, high phase gives 14 on differential channels only
                            cycLeftQ <= convLength(firstPendingQ, diffMode,
                                halfRateConvClock);
                            firstPendingQ <= 1'b0;
                        end
                    end
                    ST_CONV: begin
                        if (convTick) begin
                            cycLeftQ <= cycLeftQ - 5'h01;
                            if (cycLeftQ == 5'h02) begin
                                lockQ <= 1'b0;
                            end
                            if (cycLeftQ == 5'h01) begin
                                stateQ <= ST_SYNC;
                                sleepStartedQ <= 1'b0;
                                wakeQ <= sleepStartedQ || ctrlAQ[`ADCT_CA_IE];
                            end
                        end
                    end
                    ST_SYNC: begin
                        // free running restarts with high phase, 14 cycles on differential channels, 13 otherwise
                        if (convBusy && ctrlAQ[`ADCT_CA_ATE]) begin
                            stateQ <= ST_CONV;
                            lockQ <= 1'b1;
                            cycLeftQ <= convLength(1'b0, diffMode, 1'b1);
                        end else begin
                            stateQ <= ST_IDLE;
                        end
                    end
                    default: begin
                        stateQ <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    // =====================================================
    // Read data
    always @(posedge clk_sys) begin
        if (sys_rst) begin
            prdata <= 32'h00000000;
        end else if (apbRead) begin
            case (paddr)
                `ADCT_OFF_INSEL: prdata <= {24'h000000, inputSelectRegQ};
                `ADCT_OFF_CTRLA: prdata <= {24'h000000, ctrlAQ};
                `ADCT_OFF_SLEEP: prdata <= {28'h0000000, sleepQ};
                `ADCT_OFF_RESULT: prdata <= {22'h000000, resultQ};
                `ADCT_OFF_STATUS: prdata <= {22'h000000, stateQ, lockQ,
                    halfRateConvClock, referenceSelect, cycLeftQ[2:0]};
                default: prdata <= 32'h00000000;
            endcase
        end
    end
    // only idle or noise modes start conversions; enable untouched
endmodule // adct_conv_ctrl

// >>> logic/adct_defines.vh
// Constants for the converter timing and selection buffering block.
// Assumes inclusion by bare name from the design files.
`ifndef ADCT_DEFINES_VH
`define ADCT_DEFINES_VH
// =====================================================
// Register byte offsets on the APB slave
`define ADCT_OFF_INSEL 12'h000
`define ADCT_OFF_CTRLA 12'h004
`define ADCT_OFF_SLEEP 12'h008
`define ADCT_OFF_RESULT 12'h00c
`define ADCT_OFF_STATUS 12'h010
// =====================================================
// Field positions of the input select register
`define ADCT_SEL_CH_LSB 0
`define ADCT_SEL_CH_MSB 4
`define ADCT_SEL_REF_LSB 6
`define ADCT_SEL_REF_MSB 7
// =====================================================
// Field positions of converter control A
`define ADCT_CA_PRESC_LSB 0
`define ADCT_CA_PRESC_MSB 2
`define ADCT_CA_IE 3
`define ADCT_CA_DONE 4
`define ADCT_CA_ATE 5
`define ADCT_CA_START 6
`define ADCT_CA_EN 7
// =====================================================
// Sleep control fields
`define ADCT_SLP_REQ 0
`define ADCT_SLP_MODE_LSB 1
`define ADCT_SLP_MODE_MSB 3
`define ADCT_SLP_IDLE 3'h0
`define ADCT_SLP_NOISE 3'h1
// =====================================================
// Reference choices
`define ADCT_REF_EXTPIN 2'h0
`define ADCT_REF_SUPPLY 2'h1
`define ADCT_REF_INT256 2'h3
// =====================================================
// Conversion lengths in converter clock cycles
`define ADCT_CYC_NORMAL 5'h0d
`define ADCT_CYC_SYNC 5'h0e
`define ADCT_CYC_FIRST 5'h19
// Reset values
`define ADCT_RST_BYTE 8'h00
// Differential channel codes start at this channel value
`define ADCT_DIFF_FIRST 5'h08
`endif

// >>> logic/adct_prescaler.v
// Prescaler that makes the converter clock tick and the half-rate clock.
// Assumes a single system clock; enable and resets come from the same domain.
`include "adct_defines.vh"
module adct_prescaler (
    clk_sys,
    sys_rst,
    convEnable,
    trigReset,
    prescSel,
    convTick,
    halfRateConvClock
);
    input wire clk_sys;
    input wire sys_rst;
    input wire convEnable;
    input wire trigReset;
    input wire [2:0] prescSel;
    output reg convTick;
    output reg halfRateConvClock;

    reg [6:0] countQ;
    wire [6:0] limit;

    // Division 2,2,4,8..128 less one
    assign limit = (prescSel == 3'h0) ? 7'h01 : ((7'h01 << prescSel) - 7'h01);

    // =====================================================
    // Counter and toggle flop
    always @(posedge clk_sys) begin
        if (sys_rst || !convEnable || trigReset) begin
            countQ <= 7'h00;
            convTick <= 1'b0;
            if (sys_rst || !convEnable) begin
                halfRateConvClock <= 1'b0;
            end
        end else if (countQ >= limit) begin
            countQ <= 7'h00;
            convTick <= 1'b1;
            halfRateConvClock <= ~halfRateConvClock;
        end else begin
            countQ <= countQ + 7'h01;
            convTick <= 1'b0;
        end
    end
endmodule // adct_prescaler

// >>> logic/adct_sel_buffer.v
// Double-buffered channel and reference selection.
// Assumes lock control from the sequencer on the same clock.
`include "adct_defines.vh"
module adct_sel_buffer (
    clk_sys,
    sys_rst,
    tempChannel,
    tempReference,
    selLocked,
    channelSelect,
    referenceSelect
);
    input wire clk_sys;
    input wire sys_rst;
    input wire [4:0] tempChannel;
    input wire [1:0] tempReference;
    input wire selLocked;
    output reg [4:0] channelSelect;
    output reg [1:0] referenceSelect;

    // =====================================================
    // Copy while unlocked
    always @(posedge clk_sys) begin
        if (sys_rst) begin
            channelSelect <= 5'h00;
            referenceSelect <= 2'h0;
        end else if (!selLocked) begin
            channelSelect <= tempChannel;
            referenceSelect <= tempReference;
        end
    end
endmodule // adct_sel_buffer
